// >>> rtl/mac_word_and_move_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_move_consts.svh"

module mac_word_and_move_exec (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic sat_mode,
    output logic instr_ready,
    output logic move_done,
    output logic mac_done,
    output logic illegal_op,
    output logic [31:0] pc,
    input wire logic pc_load,
    input wire logic [31:0] pc_load_value,
    output logic [31:0] accumulator_high,
    output logic [31:0] accumulator_low,
    input wire logic mac_clear,
    input wire logic gpr_wr_en,
    input wire logic [3:0] gpr_wr_sel,
    input wire logic [31:0] gpr_wr_data,
    input wire logic [3:0] gpr_rd_sel,
    output logic [31:0] gpr_rd_data,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [3:0] mem_be,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic mac_move_pkg::op_s decode(input logic [15:0] w);
        mac_move_pkg::op_s d;
        d.kind = mac_move_pkg::K_NONE;
        d.mode = mac_move_pkg::AM_IND;
        d.size = w[1:0];
        d.dst = w[11:8];
        d.src = w[7:4];
        if (w[15:12] == `OPC_GRP_LOAD && w[3:0] == `OPC_SUB_MOVR) begin
            d.kind = mac_move_pkg::K_MOVR;
        end else if (w[15:12] == `OPC_GRP_MACW && w[3:0] == `OPC_SUB_MACW) begin
            d.kind = mac_move_pkg::K_MACW;
            d.size = `SZ_WORD;
        end else if (w[1:0] != `SZ_BAD) begin
            case (w[15:12])
                `OPC_GRP_LOAD: begin
                    if (w[3:2] == `MODE_IND) begin
                        d.kind = mac_move_pkg::K_LOAD;
                    end else if (w[3:2] == `MODE_AUTO) begin
                        d.kind = mac_move_pkg::K_LOAD;
                        d.mode = mac_move_pkg::AM_POSTINC;
                    end
                end
                `OPC_GRP_STORE: begin
                    if (w[3:2] == `MODE_IND) begin
                        d.kind = mac_move_pkg::K_STORE;
                    end else if (w[3:2] == `MODE_AUTO) begin
                        d.kind = mac_move_pkg::K_STORE;
                        d.mode = mac_move_pkg::AM_PREDEC;
                    end
                end
                `OPC_GRP_IDX: begin
                    if (w[3:2] == `MODE_AUTO) begin
                        d.kind = mac_move_pkg::K_STORE;
                        d.mode = mac_move_pkg::AM_IDX;
                    end else if (w[3:2] == `MODE_IDX_LOAD) begin
                        d.kind = mac_move_pkg::K_LOAD;
                        d.mode = mac_move_pkg::AM_IDX;
                    end
                end
                default: d.kind = mac_move_pkg::K_NONE;
            endcase
        end
        return d;
    endfunction

    function automatic logic [31:0] size_step(input logic [1:0] sz);
        logic [31:0] s;
        unique case (sz)
            `SZ_BYTE: s = `STEP_BYTE;
            `SZ_WORD: s = `STEP_WORD;
            default: s = `STEP_LONG;
        endcase
        return s;
    endfunction

    // ----------------------------------------
    // State and storage
    // ----------------------------------------
    logic [31:0] gpr_r [`NUM_GPR];
    mac_move_pkg::exec_state_e state_r;
    mac_move_pkg::op_s op_r;
    mac_move_pkg::op_s op;
    logic [31:0] oper_first_r;
    logic [31:0] product_r;
    logic acc_pend_r;
    logic [31:0] pc_r;
    logic [31:0] acc_hi_r;
    logic [31:0] acc_lo_r;
    logic move_done_r;
    logic mac_done_r;
    logic illegal_r;
    logic [31:0] gpr_rd_data_r;

    logic accept;
    logic [31:0] src_val;
    logic [31:0] dst_val;
    logic [31:0] idx_val;
    logic [31:0] step;
    logic [31:0] issue_addr;
    logic [31:0] second_addr;
    logic [31:0] op_r_src_val;
    logic [31:0] acc_hi_nxt;
    logic [31:0] acc_lo_nxt;
    logic [31:0] product_nxt;
    logic mem_finish;
    logic mac_first_ack;
    logic mac_second_ack;
    logic retire;

    mem_req_if lsu_bus ();

    assign op = decode(instr);
    // Ready again while the last MAC still accumulates
    assign instr_ready = (state_r == mac_move_pkg::ST_IDLE);
    assign accept = instr_valid && instr_ready;
    assign src_val = gpr_r[op.src];
    assign dst_val = gpr_r[op.dst];
    assign idx_val = gpr_r[`IDX_REG_SEL];
    assign step = size_step(op.size);
    assign op_r_src_val = gpr_r[op_r.src];
    assign mem_finish = (state_r == mac_move_pkg::ST_MEM) && lsu_bus.ack;
    assign mac_first_ack = (state_r == mac_move_pkg::ST_MAC_FIRST) && lsu_bus.ack;
    assign mac_second_ack = (state_r == mac_move_pkg::ST_MAC_SECOND) && lsu_bus.ack;
    assign retire = (accept && op.kind == mac_move_pkg::K_MOVR) || mem_finish || mac_second_ack;

    // ----------------------------------------
    // Address formation
    // ----------------------------------------
    always_comb begin
        issue_addr = dst_val;
        if (op.kind == mac_move_pkg::K_LOAD) begin
            if (op.mode == mac_move_pkg::AM_IDX) begin
                issue_addr = src_val + idx_val;
            end else begin
                issue_addr = src_val;
            end
        end else if (op.kind == mac_move_pkg::K_STORE) begin
            if (op.mode == mac_move_pkg::AM_PREDEC) begin
                issue_addr = dst_val - step;
            end else if (op.mode == mac_move_pkg::AM_IDX) begin
                issue_addr = dst_val + idx_val;
            end
        end
    end

    // Same register for both operands reads the stepped address
    assign second_addr = (op_r.src == op_r.dst) ? op_r_src_val + `MACW_STEP : op_r_src_val;

    // ----------------------------------------
    // Requests to the load/store unit
    // ----------------------------------------
    always_comb begin
        if (mac_first_ack) begin
            lsu_bus.start = 1'b1;
            lsu_bus.we = 1'b0;
            lsu_bus.size = `SZ_WORD;
            lsu_bus.addr = second_addr;
            lsu_bus.wdata = 32'h00000000;
        end else begin
            lsu_bus.start = accept && (op.kind == mac_move_pkg::K_LOAD || op.kind == mac_move_pkg::K_STORE
                || op.kind == mac_move_pkg::K_MACW);
            lsu_bus.we = (op.kind == mac_move_pkg::K_STORE);
            lsu_bus.size = op.size;
            lsu_bus.addr = issue_addr;
            lsu_bus.wdata = src_val;
        end
    end

    load_store_port u_port (
        .clk(clk),
        .rst_n(rst_n),
        .lsu(lsu_bus.port),
        .mem_req(mem_req),
        .mem_we(mem_we),
        .mem_addr(mem_addr),
        .mem_be(mem_be),
        .mem_wdata(mem_wdata),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= mac_move_pkg::ST_IDLE;
            op_r <= '0;
        end else begin
            unique case (state_r)
                mac_move_pkg::ST_IDLE: begin
                    if (accept) begin
                        op_r <= op;
                        if (op.kind == mac_move_pkg::K_LOAD || op.kind == mac_move_pkg::K_STORE) begin
                            state_r <= mac_move_pkg::ST_MEM;
                        end else if (op.kind == mac_move_pkg::K_MACW) begin
                            state_r <= mac_move_pkg::ST_MAC_FIRST;
                        end
                    end
                end
                mac_move_pkg::ST_MEM: begin
                    if (lsu_bus.ack) begin
                        state_r <= mac_move_pkg::ST_IDLE;
                    end
                end
                mac_move_pkg::ST_MAC_FIRST: begin
                    if (lsu_bus.ack) begin
                        state_r <= mac_move_pkg::ST_MAC_SECOND;
                    end
                end
                mac_move_pkg::ST_MAC_SECOND: begin
                    if (lsu_bus.ack) begin
                        state_r <= mac_move_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // General registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `NUM_GPR; i++) begin
                gpr_r[i] <= 32'h00000000;
            end
        end else if (accept && op.kind == mac_move_pkg::K_MOVR) begin
            gpr_r[op.dst] <= src_val;
        end else if (accept && op.kind == mac_move_pkg::K_STORE && op.mode == mac_move_pkg::AM_PREDEC) begin
            gpr_r[op.dst] <= issue_addr;
        end else if (mem_finish && op_r.kind == mac_move_pkg::K_LOAD) begin
            gpr_r[op_r.dst] <= lsu_bus.rdata;
            if (op_r.mode == mac_move_pkg::AM_POSTINC && op_r.src != op_r.dst) begin
                gpr_r[op_r.src] <= op_r_src_val + size_step(op_r.size);
            end
        end else if (mac_first_ack) begin
            gpr_r[op_r.dst] <= gpr_r[op_r.dst] + `MACW_STEP;
        end else if (mac_second_ack) begin
            gpr_r[op_r.src] <= op_r_src_val + `MACW_STEP;
        end else if (gpr_wr_en && state_r == mac_move_pkg::ST_IDLE && !accept) begin
            gpr_r[gpr_wr_sel] <= gpr_wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gpr_rd_data_r <= 32'h00000000;
        end else begin
            gpr_rd_data_r <= gpr_r[gpr_rd_sel];
        end
    end

    // ----------------------------------------
    // Multiply and accumulate
    // ----------------------------------------
    assign product_nxt = $signed(oper_first_r) * $signed(lsu_bus.rdata);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oper_first_r <= 32'h00000000;
            product_r <= 32'h00000000;
            acc_pend_r <= 1'b0;
        end else begin
            acc_pend_r <= mac_second_ack;
            if (mac_first_ack) begin
                oper_first_r <= lsu_bus.rdata;
            end
            if (mac_second_ack) begin
                product_r <= product_nxt;
            end
        end
    end

    mac_saturate_unit u_sat (
        .sat_mode(sat_mode),
        .acc_hi(acc_hi_r),
        .acc_lo(acc_lo_r),
        .product(product_r),
        .acc_hi_nxt(acc_hi_nxt),
        .acc_lo_nxt(acc_lo_nxt)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_hi_r <= 32'h00000000;
            acc_lo_r <= 32'h00000000;
        end else if (acc_pend_r) begin
            acc_hi_r <= acc_hi_nxt;
            acc_lo_r <= acc_lo_nxt;
        end else if (mac_clear) begin
            acc_hi_r <= 32'h00000000;
            acc_lo_r <= 32'h00000000;
        end
    end

    // ----------------------------------------
    // Program counter and status pulses
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= 32'h00000000;
        end else if (pc_load) begin
            pc_r <= pc_load_value;
        end else if (retire) begin
            pc_r <= pc_r + `PC_STEP;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            move_done_r <= 1'b0;
            mac_done_r <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            move_done_r <= (accept && op.kind == mac_move_pkg::K_MOVR) || mem_finish;
            mac_done_r <= acc_pend_r;
            illegal_r <= accept && op.kind == mac_move_pkg::K_NONE;
        end
    end

    assign move_done = move_done_r;
    assign mac_done = mac_done_r;
    assign illegal_op = illegal_r;
    assign pc = pc_r;
    assign accumulator_high = acc_hi_r;
    assign accumulator_low = acc_lo_r;
    assign gpr_rd_data = gpr_rd_data_r;

endmodule

`default_nettype wire

// >>> rtl/mac_move_consts.svh
`ifndef MAC_MOVE_CONSTS_SVH
`define MAC_MOVE_CONSTS_SVH

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define OPC_GRP_IDX 4'h0
`define OPC_GRP_STORE 4'h2
`define OPC_GRP_MACW 4'h4
`define OPC_GRP_LOAD 4'h6
`define OPC_SUB_MOVR 4'h3
`define OPC_SUB_MACW 4'hF
`define MODE_IND 2'h0
`define MODE_AUTO 2'h1
`define MODE_IDX_LOAD 2'h3
`define IDX_REG_SEL 4'h0
`define NUM_GPR 16

// ----------------------------------------
// Access sizes and steps
// ----------------------------------------
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define SZ_BAD 2'h3
`define STEP_BYTE 32'h00000001
`define STEP_WORD 32'h00000002
`define STEP_LONG 32'h00000004
`define PC_STEP 32'h00000002
`define MACW_STEP 32'h00000002

// ----------------------------------------
// Accumulator limits
// ----------------------------------------
`define HI_SIGN_BIT 9
`define HI_KEEP_MASK 32'h000003FF
`define HI_SET_MASK 32'hFFFFFC00
`define HI_OVF_FLAG 32'h00000001
`define SAT_MIN 32'h80000000
`define SAT_MAX 32'h7FFFFFFF

`endif

// >>> rtl/mac_move_pkg.sv
package mac_move_pkg;

    typedef enum logic [2:0] {K_NONE, K_MOVR, K_LOAD, K_STORE, K_MACW} op_kind_e;
    typedef enum logic [1:0] {AM_IND, AM_PREDEC, AM_POSTINC, AM_IDX} addr_mode_e;
    typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_MAC_FIRST, ST_MAC_SECOND} exec_state_e;
    typedef logic [1:0] size_t;

    typedef struct packed {
        op_kind_e kind;
        addr_mode_e mode;
        size_t size;
        logic [3:0] dst;
        logic [3:0] src;
    } op_s;

endpackage

// >>> rtl/mem_req_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mem_req_if;
    logic start;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;

    modport core (output start, output we, output size, output addr, output wdata, input ack, input rdata);
    modport port (input start, input we, input size, input addr, input wdata, output ack, output rdata);
endinterface

`default_nettype wire

// >>> rtl/load_store_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_move_consts.svh"

module load_store_port (
    input wire logic clk,
    input wire logic rst_n,
    mem_req_if.port lsu,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [3:0] mem_be,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    logic [1:0] size_r;
    logic [7:0] byte_sel;
    logic [15:0] half_sel;

    // ----------------------------------------
    // Request registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req <= 1'b0;
        end else if (lsu.start) begin
            mem_req <= 1'b1;
        end else if (mem_ack) begin
            mem_req <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_we <= 1'b0;
            mem_addr <= 32'h00000000;
            mem_be <= 4'h0;
            mem_wdata <= 32'h00000000;
            size_r <= `SZ_BYTE;
        end else if (lsu.start) begin
            mem_we <= lsu.we;
            mem_addr <= lsu.addr;
            size_r <= lsu.size;
            // Only the lanes of the chosen size are enabled
            unique case (lsu.size)
                `SZ_BYTE: begin
                    mem_be <= 4'h1 << lsu.addr[1:0];
                    mem_wdata <= {4{lsu.wdata[7:0]}};
                end
                `SZ_WORD: begin
                    mem_be <= lsu.addr[1] ? 4'hC : 4'h3;
                    mem_wdata <= {2{lsu.wdata[15:0]}};
                end
                default: begin
                    mem_be <= 4'hF;
                    mem_wdata <= lsu.wdata;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Answer and sign extension
    // ----------------------------------------
    assign lsu.ack = mem_req && mem_ack;

    always_comb begin
        unique case (mem_addr[1:0])
            2'h0: byte_sel = mem_rdata[7:0];
            2'h1: byte_sel = mem_rdata[15:8];
            2'h2: byte_sel = mem_rdata[23:16];
            default: byte_sel = mem_rdata[31:24];
        endcase
        half_sel = mem_addr[1] ? mem_rdata[31:16] : mem_rdata[15:0];
        unique case (size_r)
            `SZ_BYTE: lsu.rdata = {{24{byte_sel[7]}}, byte_sel};
            `SZ_WORD: lsu.rdata = {{16{half_sel[15]}}, half_sel};
            default: lsu.rdata = mem_rdata;
        endcase
    end

endmodule

`default_nettype wire

// >>> rtl/mac_saturate_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_move_consts.svh"

module mac_saturate_unit (
    input wire logic sat_mode,
    input wire logic [31:0] acc_hi,
    input wire logic [31:0] acc_lo,
    input wire logic [31:0] product,
    output logic [31:0] acc_hi_nxt,
    output logic [31:0] acc_lo_nxt
);
    logic [63:0] sum64;
    logic [32:0] sum33;

    always_comb begin
        sum64 = {acc_hi, acc_lo} + {{32{product[31]}}, product};
        sum33 = {acc_lo[31], acc_lo} + {product[31], product};
        if (!sat_mode) begin
            acc_lo_nxt = sum64[31:0];
            if (sum64[32 + `HI_SIGN_BIT]) begin
                acc_hi_nxt = sum64[63:32] | `HI_SET_MASK;
            end else begin
                acc_hi_nxt = sum64[63:32] & `HI_KEEP_MASK;
            end
        end else if (sum33[32] != sum33[31]) begin
            acc_hi_nxt = acc_hi | `HI_OVF_FLAG;
            acc_lo_nxt = sum33[32] ? `SAT_MIN : `SAT_MAX;
        end else begin
            acc_hi_nxt = acc_hi;
            acc_lo_nxt = sum33[31:0];
        end
    end

endmodule

`default_nettype wire

// >>> dv/exec_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_move_consts.svh"

module exec_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic sat_mode,
    input wire logic instr_ready,
    input wire logic move_done,
    input wire logic mac_done,
    input wire logic illegal_op,
    input wire logic [31:0] pc,
    input wire logic pc_load,
    input wire logic [31:0] accumulator_high,
    input wire logic [31:0] accumulator_low,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [3:0] mem_be,
    input wire logic mem_ack
);
    logic take;
    assign take = instr_valid && instr_ready;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    be_size_a: assert property (mem_req && mem_we |-> mem_be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
        else $error("store enables match no access size");
    mac_time_a: assert property (take && instr[15:12] == 4'h4 && instr[3:0] == 4'hF ##1 mem_ack ##1 mem_ack
        |-> ##1 instr_ready ##1 mac_done)
        else $error("word mac timing wrong");
    mov_one_a: assert property (take && instr[15:12] == 4'h6 && instr[3:0] == 4'h3 |=> move_done)
        else $error("register move not done in one cycle");
    pc_step_a: assert property ($changed(pc) && !$past(pc_load) |-> pc == $past(pc) + 32'h00000002)
        else $error("pc step is not two");
    hi_sext_a: assert property (mac_done && !$past(sat_mode) |->
        accumulator_high[31:10] == {22{accumulator_high[9]}})
        else $error("high accumulator not sign extended");
    sat_hi_a: assert property (mac_done && $past(sat_mode)
        |-> (accumulator_high | 32'h00000001) == ($past(accumulator_high) | 32'h00000001))
        else $error("saturating mac changed high accumulator");
    sat_clamp_a: assert property (mac_done && $past(sat_mode) && accumulator_high[0] && !$past(accumulator_high[0])
        |-> accumulator_low == `SAT_MAX || accumulator_low == `SAT_MIN)
        else $error("overflow without clamp");
    bad_size_a: assert property (take && instr[15:12] == 4'h2 && instr[3:0] == 4'h3 |=> illegal_op && !mem_req)
        else $error("bad size code not refused");
endmodule

bind mac_word_and_move_exec exec_sva i_exec_sva (.*);

`default_nettype wire

// >>> dv/mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:63];
    logic wait_r;
    logic [31:0] word;
    assign word = mem[mem_addr[7:2]];
    assign mem_ack = mem_req && (!slow || wait_r);
    // Inverted data outside ack, never a stale match
    assign mem_rdata = mem_ack ? word : ~word;
    always_ff @(posedge clk) wait_r <= rst_n && mem_req && !mem_ack;
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (mem_ack && mem_we && mem_be[i]) begin
                mem[mem_addr[7:2]][8*i +: 8] <= mem_wdata[8*i +: 8];
            end
        end
    end
endmodule

`default_nettype wire

// >>> dv/mac_word_and_move_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_move_consts.svh"

module mac_word_and_move_exec_tb;
    logic clk = 0, rst_n = 0, instr_valid = 0, sat_mode = 0, pc_load = 0, mac_clear = 0;
    logic gpr_wr_en = 0, slow = 0, rd_v = 0, rd_v_d = 0;
    logic [15:0] instr = 16'h0000;
    logic [3:0] gpr_wr_sel = 4'h0, gpr_rd_sel = 4'h0, mem_be;
    logic [31:0] pc_load_value = 32'h00000000, gpr_wr_data = 32'h00000000, seed = 32'h00009161;
    logic instr_ready, move_done, mac_done, illegal_op, mem_req, mem_we, mem_ack;
    logic [31:0] pc, accumulator_high, accumulator_low, gpr_rd_data, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] ref_m [0:63];
    logic [31:0] rd_q [$], hi_q [$], lo_q [$];
    logic [31:0] hi_m, lo_m, r3, p;
    logic [1:0] szs [0:3] = '{2'h0, 2'h0, 2'h1, 2'h2};
    int mismatches = 0, samples_checked = 0, n_ops = 0;

    mac_word_and_move_exec i_mac_word_and_move_exec (.*);
    mem_model i_mem_model (.*);

    initial forever #20 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] ld(input logic [31:0] a, input logic [1:0] sz);
        logic [31:0] w;
        w = ref_m[a[7:2]] >> (8 * a[1:0]);
        case (sz)
            2'h0: return {{24{w[7]}}, w[7:0]};
            2'h1: return {{16{w[15]}}, w[15:0]};
            default: return ref_m[a[7:2]];
        endcase
    endfunction
    task automatic wref(input logic [31:0] a, input logic [1:0] sz, input logic [31:0] d);
        for (int i = 0; i < (1 << sz); i++)
            ref_m[a[7:2]][8 * (a[1:0] + i) +: 8] = d[8*i +: 8];
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        gpr_wr_en <= 1'b1;
        gpr_wr_sel <= s;
        gpr_wr_data <= d;
        @(posedge clk);
        gpr_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] s, input logic [31:0] e);
        @(posedge clk);
        gpr_rd_sel <= s;
        rd_v <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        rd_v <= 1'b0;
        @(posedge clk);
    endtask
    task automatic issue(input logic [15:0] op);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= op;
        @(negedge clk);
        for (int k = 0; k < 50 && instr_ready !== 1'b1; k++)
            @(negedge clk);
        if (instr_ready !== 1'b1) mismatches++;
        @(posedge clk);
        instr_valid <= 1'b0;
        n_ops++;
    endtask
    task automatic settle;
        @(negedge clk);
        for (int k = 0; k < 50 && (instr_ready !== 1'b1 || lo_q.size() > 0); k++)
            @(negedge clk);
        if (instr_ready !== 1'b1 || lo_q.size() > 0) mismatches++;
    endtask
    task automatic mac(input logic [31:0] a, input logic [31:0] b);
        logic signed [31:0] pr;
        logic signed [63:0] s;
        pr = $signed(ld(a, 2'h1)) * $signed(ld(b, 2'h1));
        s = $signed(lo_m) + pr;
        if (sat_mode) begin
            hi_m[0] = hi_m[0] | s > $signed(`SAT_MAX) | s < $signed(`SAT_MIN);
            lo_m = s > $signed(`SAT_MAX) ? `SAT_MAX : s < $signed(`SAT_MIN) ? `SAT_MIN : s[31:0];
        end else begin
            {hi_m, lo_m} = {hi_m, lo_m} + {{32{pr[31]}}, pr};
            hi_m = {{22{hi_m[9]}}, hi_m[9:0]};
        end
        lo_q.push_back(lo_m);
        hi_q.push_back(hi_m);
        issue(16'h4ABF);
    endtask
    task automatic macs(input logic [31:0] a, input logic [31:0] b);
        wr(10, a);
        wr(11, b);
        @(posedge clk);
        mac_clear <= 1'b1;
        @(posedge clk);
        mac_clear <= 1'b0;
        hi_m = 32'h00000000;
        lo_m = 32'h00000000;
        for (int k = 0; k < 3; k++)
            mac(a + 2 * k, b + 2 * k);
        settle;
    endtask

    always @(posedge clk) begin
        rd_v_d <= rd_v;
        if (rd_v_d === 1'b1)
            check("gpr", gpr_rd_data, rd_q.pop_front());
        if (mac_done === 1'b1) begin
            check("acc_low", accumulator_low, lo_q.pop_front());
            check("acc_high", accumulator_high, hi_q.pop_front());
        end
    end

    initial begin
        #200000;
        mismatches++;
        print_verdict;
    end

    initial begin
        for (int i = 0; i < 64; i++) begin
            seed = lfsr(seed);
            ref_m[i] = seed;
        end
        ref_m[24] = 32'h80FF7F80;
        ref_m[40] = 32'h80008000;
        ref_m[41] = 32'h80008000;
        ref_m[42] = 32'h7FFF7FFF;
        ref_m[43] = 32'h7FFF7FFF;
        ref_m[44] = 32'h80008000;
        ref_m[45] = 32'h80008000;
        for (int i = 0; i < 64; i++)
            i_mem_model.mem[i] = ref_m[i];
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        pc_load <= 1'b1;
        pc_load_value <= 32'h00000100;
        @(posedge clk);
        pc_load <= 1'b0;
        r3 = lfsr(seed);
        wr(0, 32'h00000004);
        wr(1, 32'h00000040);
        wr(2, 32'h00000060);
        wr(3, r3);
        wr(4, 32'h00000020);
        issue(16'h6533);
        settle;
        rd(5, r3);
        p = 32'h00000040;
        for (int s = 2; s >= 0; s--) begin
            issue({14'h084D, s[1:0]});
            settle;
            p = p - (32'h00000001 << s);
            wref(p, s[1:0], r3);
            rd(1, p);
        end
        issue(16'h0436);
        settle;
        wref(32'h00000024, 2'h2, r3);
        rd(4, 32'h00000020);
        issue(16'h2430);
        settle;
        wref(32'h00000020, 2'h0, r3);
        issue(16'h6841);
        settle;
        rd(8, ld(32'h00000020, 2'h1));
        p = 32'h00000060;
        for (int k = 0; k < 4; k++) begin
            issue({14'h1989, szs[k]});
            settle;
            rd(6, ld(p, szs[k]));
            p = p + (32'h00000001 << szs[k]);
            rd(2, p);
        end
        issue(16'h6226);
        settle;
        rd(2, ld(32'h00000068, 2'h2));
        for (int k = 0; k < 3; k++) begin
            issue({14'h01D3, k[1:0]});
            settle;
            rd(7, ld(32'h00000024, k[1:0]));
        end
        macs(32'h00000080, 32'h00000084);
        rd(10, 32'h00000086);
        rd(11, 32'h0000008A);
        @(posedge clk);
        sat_mode <= 1'b1;
        slow <= 1'b1;
        macs(32'h000000A0, 32'h000000A4);
        macs(32'h000000B0, 32'h000000A8);
        issue(16'h2013);
        n_ops--;
        settle;
        check("pc", pc, 32'h00000100 + 32'(2 * n_ops));
        for (int i = 8; i < 16; i++)
            check("mem", i_mem_model.mem[i], ref_m[i]);
        print_verdict;
    end
endmodule

`default_nettype wire
